// ===== rtl/remote_cal_status_link_regs.vh
// Constants for the remote calibration and serial status link
`ifndef REMOTE_CAL_STATUS_LINK_REGS_VH
`define REMOTE_CAL_STATUS_LINK_REGS_VH

// Clock and serial timing
`define CLK_HZ            10000000
`define BAUD_RATE         2400
`define BIT_CYCLES        (`CLK_HZ / `BAUD_RATE)
`define REPORT_SECONDS    2
`define REPORT_CYCLES     (`CLK_HZ * `REPORT_SECONDS)
`define CAL_CYCLES_DEF    1000000
`define DATA_BITS         8

// Range codes
`define RANGE_LO          2'h0
`define RANGE_MED         2'h1
`define RANGE_HI          2'h2
`define RANGE_AIR         2'h3

// Default full scale spans in ppm, air range in percent
`define SPAN_LO_PPM       16'h000a
`define SPAN_MED_PPM      16'h0064
`define SPAN_HI_PPM       16'h00fa
`define SPAN_AIR_PCT      16'h0019

// Default alarm setpoint, hundredths of ppm
`define ALARM_SETPOINT    16'h03e8

// Characters
`define CH_CR             8'h0d
`define CH_LF             8'h0a
`define CH_A              8'h61
`define CH_S              8'h73
`define CH_Z              8'h7a
`define CH_T              8'h74
`define CH_SPACE          8'h20
`define CH_ZERO           8'h30
`define CH_P              8'h70
`define CH_M              8'h6d
`define CH_PCT            8'h25
`define CH_D              8'h44
`define CH_N              8'h4e
`define CH_L              8'h4c

`endif

// ===== rtl/byte_fifo.v
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // byte_fifo

`default_nettype wire

// ===== rtl/remote_cal_status_link.v
// Remote calibration handshake, range relays, valves and serial status link
`timescale 1ns/1ps
`default_nettype none
`include "remote_cal_status_link_regs.vh"

module remote_cal_status_link #(
    parameter BIT_CYC    = `BIT_CYCLES,
    parameter REPORT_CYC = `REPORT_CYCLES,
    parameter CAL_CYC    = `CAL_CYCLES_DEF,
    parameter FIFO_DEPTH = 8
) (
    input  wire        REF_CLK_IN,
    input  wire        NRST_IN,
    input  wire        REMOTE_ZERO_IN,
    input  wire        REMOTE_SPAN_IN,
    input  wire [15:0] CONC_IN,
    input  wire [1:0]  RANGE_SEL_IN,
    input  wire [1:0]  ALARM_TRIP_IN,
    input  wire        RXD_IN,
    input  wire        NET_IN,
    output reg         TXD_OUT,
    output reg         CAL_BUSY_OUT,
    output reg  [3:0]  RANGE_RELAY_OUT,
    output reg         VALVE_SAMPLE_OUT,
    output reg         VALVE_ZERO_OUT,
    output reg         VALVE_SPAN_OUT,
    output reg         VALVE_EXHAUST_OUT,
    output reg         NET_OUT,
    output reg         NET_OE_OUT,
    output reg         STATUS_EN_OUT
);

    // ========================================================
    // Calibration sequencer
    localparam CAL_IDLE = 2'h0;
    localparam CAL_ZERO = 2'h1;
    localparam CAL_SPAN = 2'h2;

    reg [1:0]  cal_state;
    reg [31:0] cal_cnt;
    reg        cmd_auto_zero;
    reg        cmd_auto_span;
    reg        cmd_status_toggle;
    reg [15:0] alarm_enable;
    wire       cal_done = (cal_cnt == CAL_CYC - 1);

    // Idle polls inputs; busy ignores new requests; held input restarts
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cal_state <= CAL_IDLE;
            cal_cnt   <= 32'h0;
        end else begin
            case (cal_state)
                CAL_IDLE: begin
                    cal_cnt <= 32'h0;
                    if (REMOTE_ZERO_IN || cmd_auto_zero) begin
                        cal_state <= CAL_ZERO;
                    end else if (REMOTE_SPAN_IN || cmd_auto_span) begin
                        cal_state <= CAL_SPAN;
                    end
                end
                CAL_ZERO, CAL_SPAN: begin
                    if (cal_done) begin
                        cal_cnt <= 32'h0;
                        if (REMOTE_ZERO_IN) begin
                            cal_state <= CAL_ZERO;
                        end else if (REMOTE_SPAN_IN) begin
                            cal_state <= CAL_SPAN;
                        end else begin
                            cal_state <= CAL_IDLE;
                        end
                    end else begin
                        cal_cnt <= cal_cnt + 32'h1;
                    end
                end
                default: begin
                    cal_state <= CAL_IDLE;
                    cal_cnt   <= 32'h0;
                end
            endcase
        end
    end

    // Busy contact, valves and range relays from flip-flops
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CAL_BUSY_OUT      <= 1'b0;
            VALVE_SAMPLE_OUT  <= 1'b1;
            VALVE_ZERO_OUT    <= 1'b0;
            VALVE_SPAN_OUT    <= 1'b0;
            VALVE_EXHAUST_OUT <= 1'b1;
            RANGE_RELAY_OUT   <= 4'h1;
            NET_OUT           <= 1'b0;
            NET_OE_OUT        <= 1'b0;
        end else begin
            CAL_BUSY_OUT      <= (cal_state != CAL_IDLE);
            VALVE_SAMPLE_OUT  <= (cal_state == CAL_IDLE);
            VALVE_ZERO_OUT    <= (cal_state == CAL_ZERO);
            VALVE_SPAN_OUT    <= (cal_state == CAL_SPAN);
            VALVE_EXHAUST_OUT <= 1'b1;
            RANGE_RELAY_OUT   <= 4'h1 << RANGE_SEL_IN;
            NET_OUT           <= 1'b0;
            NET_OE_OUT        <= 1'b0;
        end
    end

    // ========================================================
    // Serial receiver, 8N1
    reg [31:0] rx_cnt;
    reg [3:0]  rx_bit;
    reg [7:0]  rx_shift;
    reg        rx_busy;
    reg        rx_strobe;
    reg [7:0]  rx_byte;

    // Start bit found, sample each bit at its middle
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rx_cnt    <= 32'h0;
            rx_bit    <= 4'h0;
            rx_shift  <= 8'h00;
            rx_busy   <= 1'b0;
            rx_strobe <= 1'b0;
            rx_byte   <= 8'h00;
        end else begin
            rx_strobe <= 1'b0;
            if (!rx_busy) begin
                if (!RXD_IN) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= BIT_CYC / 2;
                    rx_bit  <= 4'h0;
                end
            end else if (rx_cnt != 32'h0) begin
                rx_cnt <= rx_cnt - 32'h1;
            end else begin
                rx_cnt <= BIT_CYC - 1;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && RXD_IN) begin
                    rx_busy <= 1'b0;
                end else if (rx_bit >= 4'h1 && rx_bit <= `DATA_BITS) begin
                    rx_shift <= {RXD_IN, rx_shift[7:1]};
                end else if (rx_bit == `DATA_BITS + 1) begin
                    rx_busy <= 1'b0;
                    if (RXD_IN) begin
                        rx_strobe <= 1'b1;
                        rx_byte   <= rx_shift;
                    end
                end
            end
        end
    end

    // ========================================================
    // Command interpreter
    reg [7:0] hist0;
    reg [7:0] hist1;
    reg [1:0] hist_len;

    // Two letters then Enter; Enter always clears history, LF is skipped
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hist0             <= 8'h00;
            hist1             <= 8'h00;
            hist_len          <= 2'h0;
            cmd_auto_zero     <= 1'b0;
            cmd_auto_span     <= 1'b0;
            cmd_status_toggle <= 1'b0;
        end else begin
            cmd_status_toggle <= 1'b0;
            if (cal_state != CAL_IDLE) begin
                cmd_auto_zero <= 1'b0;
                cmd_auto_span <= 1'b0;
            end
            if (rx_strobe) begin
                if (rx_byte == `CH_CR) begin
                    hist_len <= 2'h0;
                    if (hist_len == 2'h2 && hist1 == `CH_A && hist0 == `CH_S) begin
                        cmd_auto_span <= 1'b1;
                    end else if (hist_len == 2'h2 && hist1 == `CH_A && hist0 == `CH_Z) begin
                        cmd_auto_zero <= 1'b1;
                    end else if (hist_len == 2'h2 && hist1 == `CH_S && hist0 == `CH_T) begin
                        cmd_status_toggle <= 1'b1;
                    end
                end else if (rx_byte == `CH_LF) begin
                    hist_len <= hist_len;
                end else begin
                    hist1    <= hist0;
                    hist0    <= rx_byte;
                    hist_len <= (hist_len == 2'h3) ? 2'h3 : hist_len + 2'h1;
                end
            end
        end
    end

    // Status enable toggles on each st command
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            STATUS_EN_OUT <= 1'b1;
            alarm_enable  <= 16'h0000;
        end else if (cmd_status_toggle) begin
            STATUS_EN_OUT <= ~STATUS_EN_OUT;
        end
    end

    // ========================================================
    // Report builder
    function [7:0] digit;
        input [3:0] v;
        begin
            digit = `CH_ZERO + {4'h0, v};
        end
    endfunction

    function [15:0] span_of;
        input [1:0] r;
        begin
            case (r)
                `RANGE_LO:  span_of = `SPAN_LO_PPM;
                `RANGE_MED: span_of = `SPAN_MED_PPM;
                `RANGE_HI:  span_of = `SPAN_HI_PPM;
                default:    span_of = `SPAN_AIR_PCT;
            endcase
        end
    endfunction

    reg [31:0] rep_cnt;
    reg [4:0]  rep_idx;
    reg        rep_run;
    reg [15:0] conc_snap;
    reg [1:0]  rng_snap;
    reg [1:0]  trip_snap;
    reg [7:0]  rep_char;
    wire       fifo_ready;
    wire [7:0] tx_data;
    wire       tx_valid;
    reg        tx_take;
    wire [15:0] span_val = span_of(rng_snap);

    // Report text: conc CRLF range CRLF span CRLF alarms CRLF
    always @* begin
        case (rep_idx)
            5'h00: rep_char = digit(conc_snap[15:12]);
            5'h01: rep_char = digit(conc_snap[11:8]);
            5'h02: rep_char = digit(conc_snap[7:4]);
            5'h03: rep_char = digit(conc_snap[3:0]);
            5'h04: rep_char = (rng_snap == `RANGE_AIR) ? `CH_PCT : `CH_P;
            5'h05, 5'h0a, 5'h12, 5'h17: rep_char = `CH_CR;
            5'h06, 5'h0b, 5'h13, 5'h18: rep_char = `CH_LF;
            5'h07: rep_char = (rng_snap == `RANGE_HI)  ? `CH_P :
                              (rng_snap == `RANGE_MED) ? `CH_M : `CH_L;
            5'h08: rep_char = digit({2'h0, rng_snap});
            5'h09: rep_char = `CH_SPACE;
            5'h0c: rep_char = digit(span_val[15:12]);
            5'h0d: rep_char = digit(span_val[11:8]);
            5'h0e: rep_char = digit(span_val[7:4]);
            5'h0f: rep_char = digit(span_val[3:0]);
            5'h10: rep_char = alarm_enable[0] ? `CH_SPACE : `CH_D;
            5'h11: rep_char = alarm_enable[1] ? `CH_SPACE : `CH_D;
            5'h14: rep_char = trip_snap[0] ? `CH_N : `CH_SPACE;
            5'h15: rep_char = trip_snap[1] ? `CH_N : `CH_SPACE;
            5'h16: rep_char = `CH_SPACE;
            default: rep_char = `CH_SPACE;
        endcase
    end

    // Interval timer and character stream into the FIFO
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rep_cnt   <= 32'h0;
            rep_idx   <= 5'h00;
            rep_run   <= 1'b0;
            conc_snap <= 16'h0000;
            rng_snap  <= `RANGE_LO;
            trip_snap <= 2'h0;
        end else begin
            if (rep_cnt == REPORT_CYC - 1) begin
                rep_cnt <= 32'h0;
                if (STATUS_EN_OUT && !rep_run) begin
                    rep_run   <= 1'b1;
                    rep_idx   <= 5'h00;
                    conc_snap <= CONC_IN;
                    rng_snap  <= RANGE_SEL_IN;
                    trip_snap <= ALARM_TRIP_IN;
                end
            end else begin
                rep_cnt <= rep_cnt + 32'h1;
            end
            if (rep_run && fifo_ready) begin
                if (rep_idx == 5'h18) begin
                    rep_run <= 1'b0;
                end else begin
                    rep_idx <= rep_idx + 5'h01;
                end
            end
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_tx_fifo (
        .clk       (REF_CLK_IN),
        .rst_n     (NRST_IN),
        .in_data   (rep_char),
        .in_valid  (rep_run),
        .in_ready  (fifo_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_take)
    );

    // ========================================================
    // Serial transmitter, 8N1
    reg [31:0] tx_cnt;
    reg [3:0]  tx_bit;
    reg [9:0]  tx_shift;
    reg        tx_busy;

    // Shift start, data LSB first, stop
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tx_cnt   <= 32'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_busy  <= 1'b0;
            tx_take  <= 1'b0;
            TXD_OUT  <= 1'b1;
        end else begin
            tx_take <= 1'b0;
            if (!tx_busy) begin
                TXD_OUT <= 1'b1;
                if (tx_valid && !tx_take) begin
                    tx_shift <= {1'b1, tx_data, 1'b0};
                    tx_busy  <= 1'b1;
                    tx_take  <= 1'b1;
                    tx_bit   <= 4'h0;
                    tx_cnt   <= 32'h0;
                end
            end else if (tx_cnt != 32'h0) begin
                tx_cnt <= tx_cnt - 32'h1;
            end else if (tx_bit == `DATA_BITS + 2) begin
                tx_busy <= 1'b0;
            end else begin
                TXD_OUT  <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bit   <= tx_bit + 4'h1;
                tx_cnt   <= BIT_CYC - 1;
            end
        end
    end

endmodule // remote_cal_status_link

`default_nettype wire

// ===== sim/remote_cal_status_link_props.sv
// Port-level assertion checker for the calibration and status link
`timescale 1ns/1ps
`default_nettype none
module remote_cal_status_link_props #(
    parameter BIT_CYC    = 8,
    parameter REPORT_CYC = 4000,
    parameter CAL_CYC    = 50
) (
    input wire logic       REF_CLK_IN,
    input wire logic       NRST_IN,
    input wire logic       REMOTE_ZERO_IN,
    input wire logic       REMOTE_SPAN_IN,
    input wire logic [1:0] RANGE_SEL_IN,
    input wire logic       RXD_IN,
    input wire logic       TXD_OUT,
    input wire logic       CAL_BUSY_OUT,
    input wire logic [3:0] RANGE_RELAY_OUT,
    input wire logic       VALVE_SAMPLE_OUT,
    input wire logic       VALVE_ZERO_OUT,
    input wire logic       VALVE_SPAN_OUT,
    input wire logic       VALVE_EXHAUST_OUT,
    input wire logic       NET_OUT,
    input wire logic       NET_OE_OUT,
    input wire logic       STATUS_EN_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // ========
    // Run lengths of busy, low line and quiet line
    logic [31:0] busy_run;
    logic [31:0] low_run;
    logic [31:0] quiet;
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            busy_run <= 32'h0;
            low_run  <= 32'h0;
            quiet    <= 32'h0;
        end else begin
            busy_run <= CAL_BUSY_OUT ? busy_run + 32'h1 : 32'h0;
            low_run  <= TXD_OUT ? 32'h0 : low_run + 32'h1;
            quiet    <= (!TXD_OUT || !STATUS_EN_OUT) ? 32'h0 : quiet + 32'h1;
        end
    end
    // ========
    // Request and answer steps
    sequence zero_req; !CAL_BUSY_OUT && REMOTE_ZERO_IN; endsequence
    sequence span_req; !CAL_BUSY_OUT && REMOTE_SPAN_IN && !REMOTE_ZERO_IN; endsequence
    sequence cal_taken; ##[1:3] CAL_BUSY_OUT; endsequence
    zero_start_a: assert property (zero_req |-> cal_taken ##0 VALVE_ZERO_OUT)
        else $error("zero request not taken");
    span_start_a: assert property (span_req |-> cal_taken ##0 VALVE_SPAN_OUT)
        else $error("span request not taken");
    busy_span_a: assert property ($fell(CAL_BUSY_OUT) |-> busy_run >= CAL_CYC - 1)
        else $error("busy contact opened early");
    valve_mode_a: assert property (CAL_BUSY_OUT |->
        !VALVE_SAMPLE_OUT && (VALVE_ZERO_OUT != VALVE_SPAN_OUT))
        else $error("valves not in calibration mode");
    fixed_outs_a: assert property (VALVE_EXHAUST_OUT && !NET_OE_OUT && !NET_OUT)
        else $error("exhaust or network pin wrong");
    relay_range_a: assert property ($stable(RANGE_SEL_IN) [*3] |->
        RANGE_RELAY_OUT == (4'h1 << RANGE_SEL_IN))
        else $error("range relay wrong");
    toggle_idle_a: assert property ($changed(STATUS_EN_OUT) |-> $past(RXD_IN) && RXD_IN)
        else $error("status toggled outside stop bit");
    tx_bits_a: assert property ($rose(TXD_OUT) |-> low_run % BIT_CYC == 0)
        else $error("serial bit time wrong");
    report_period_a: assert property (quiet <= REPORT_CYC + 16)
        else $error("status report overdue");
endmodule // remote_cal_status_link_props

bind remote_cal_status_link remote_cal_status_link_props #(
    .BIT_CYC(BIT_CYC), .REPORT_CYC(REPORT_CYC), .CAL_CYC(CAL_CYC)
) i_remote_cal_status_link_props (
    .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .REMOTE_ZERO_IN(REMOTE_ZERO_IN),
    .REMOTE_SPAN_IN(REMOTE_SPAN_IN), .RANGE_SEL_IN(RANGE_SEL_IN), .RXD_IN(RXD_IN),
    .TXD_OUT(TXD_OUT), .CAL_BUSY_OUT(CAL_BUSY_OUT), .RANGE_RELAY_OUT(RANGE_RELAY_OUT),
    .VALVE_SAMPLE_OUT(VALVE_SAMPLE_OUT), .VALVE_ZERO_OUT(VALVE_ZERO_OUT),
    .VALVE_SPAN_OUT(VALVE_SPAN_OUT), .VALVE_EXHAUST_OUT(VALVE_EXHAUST_OUT),
    .NET_OUT(NET_OUT), .NET_OE_OUT(NET_OE_OUT), .STATUS_EN_OUT(STATUS_EN_OUT)
);
`default_nettype wire

// ===== sim/serial_host_model.sv
// Serial terminal model: sends commands, collects status characters
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
    parameter BIT_CYC = 8
) (
    input  wire logic clk_in,
    input  wire logic txd_in,
    output var  logic rxd_out
);
    logic [7:0] got_q[$];
    int         frame_errs;
    // ========
    // One 8N1 character, low bit first, line left at mark
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            rxd_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk_in);
        end
    endtask
    // Receiver runs beside the sender, mid-bit sampling
    initial begin
        logic [7:0] b;
        rxd_out = 1'b1;
        frame_errs = 0;
        forever begin
            @(negedge txd_in);
            repeat (BIT_CYC / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk_in);
                b[i] = txd_in;
            end
            repeat (BIT_CYC) @(posedge clk_in);
            if (txd_in !== 1'b1) frame_errs++;
            got_q.push_back(b);
        end
    end
endmodule // serial_host_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking testbench for the calibration and status link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BITC = 8;
    localparam int REPC = 4000;
    localparam int CALC = 50;
    logic        REF_CLK_IN;
    logic        NRST_IN;
    logic        REMOTE_ZERO_IN;
    logic        REMOTE_SPAN_IN;
    logic [15:0] CONC_IN;
    logic [1:0]  RANGE_SEL_IN;
    logic [1:0]  ALARM_TRIP_IN;
    logic        RXD_IN;
    logic        NET_IN;
    logic        TXD_OUT;
    logic        CAL_BUSY_OUT;
    logic [3:0]  RANGE_RELAY_OUT;
    logic        VALVE_SAMPLE_OUT;
    logic        VALVE_ZERO_OUT;
    logic        VALVE_SPAN_OUT;
    logic        VALVE_EXHAUST_OUT;
    logic        NET_OUT;
    logic        NET_OE_OUT;
    logic        STATUS_EN_OUT;
    int          failures;
    int          samples_checked;
    remote_cal_status_link #(.BIT_CYC(BITC), .REPORT_CYC(REPC), .CAL_CYC(CALC))
        i_remote_cal_status_link (
        .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .REMOTE_ZERO_IN(REMOTE_ZERO_IN),
        .REMOTE_SPAN_IN(REMOTE_SPAN_IN), .CONC_IN(CONC_IN), .RANGE_SEL_IN(RANGE_SEL_IN),
        .ALARM_TRIP_IN(ALARM_TRIP_IN), .RXD_IN(RXD_IN), .NET_IN(NET_IN), .TXD_OUT(TXD_OUT),
        .CAL_BUSY_OUT(CAL_BUSY_OUT), .RANGE_RELAY_OUT(RANGE_RELAY_OUT),
        .VALVE_SAMPLE_OUT(VALVE_SAMPLE_OUT), .VALVE_ZERO_OUT(VALVE_ZERO_OUT),
        .VALVE_SPAN_OUT(VALVE_SPAN_OUT), .VALVE_EXHAUST_OUT(VALVE_EXHAUST_OUT),
        .NET_OUT(NET_OUT), .NET_OE_OUT(NET_OE_OUT), .STATUS_EN_OUT(STATUS_EN_OUT));
    serial_host_model #(.BIT_CYC(BITC)) i_serial_host_model (
        .clk_in(REF_CLK_IN), .txd_in(TXD_OUT), .rxd_out(RXD_IN));
    // ========
    // Clock and compare helpers
    initial begin
        REF_CLK_IN = 1'b0;
        forever #50 REF_CLK_IN = ~REF_CLK_IN;
    end
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("Counts: %0d compared, %0d mismatched", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded wait for the busy contact, sampled on falling edges
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (CAL_BUSY_OUT !== lvl && n < lim) begin
            @(negedge REF_CLK_IN);
            n++;
        end
        check_bit("busy contact", lvl, CAL_BUSY_OUT);
    endtask
    task automatic send_cmd(input logic [7:0] c0, input logic [7:0] c1);
        i_serial_host_model.send_byte(c0);
        i_serial_host_model.send_byte(c1);
        i_serial_host_model.send_byte(8'h0d);
    endtask
    // ========
    // Scenarios
    task automatic t_reset_vals;
        check_bit("busy", 1'b0, CAL_BUSY_OUT);
        check_byte("relays", 8'h01, {4'h0, RANGE_RELAY_OUT});
        check_bit("sample valve", 1'b1, VALVE_SAMPLE_OUT);
        check_bit("exhaust valve", 1'b1, VALVE_EXHAUST_OUT);
        check_bit("net enable", 1'b0, NET_OE_OUT);
        check_bit("status enable", 1'b1, STATUS_EN_OUT);
        $display("test reset values done");
    endtask
    task automatic t_report;
        logic [7:0] exp [25];
        int n;
        exp = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h70, 8'h0d, 8'h0a, 8'h6d, 8'h31, 8'h20,
                8'h0d, 8'h0a, 8'h30, 8'h30, 8'h36, 8'h34, 8'h44, 8'h44, 8'h0d, 8'h0a,
                8'h4e, 8'h4e, 8'h20, 8'h0d, 8'h0a};
        n = 0;
        while (i_serial_host_model.got_q.size() < 25 && n < REPC + 4000) begin
            @(negedge REF_CLK_IN);
            n++;
        end
        for (int i = 0; i < 25; i++)
            check_byte("report char", exp[i], i_serial_host_model.got_q[i]);
        $display("test status report done");
    endtask
    task automatic t_ranges;
        for (int r = 0; r < 4; r++) begin
            @(posedge REF_CLK_IN);
            RANGE_SEL_IN <= r[1:0];
            repeat (3) @(negedge REF_CLK_IN);
            check_byte("range relays", 8'h01 << r, {4'h0, RANGE_RELAY_OUT});
        end
        $display("test range relays done");
    endtask
    task automatic t_remote_cal;
        @(posedge REF_CLK_IN);
        REMOTE_ZERO_IN <= 1'b1;
        wait_busy(1'b1, 10);
        check_bit("zero valve", 1'b1, VALVE_ZERO_OUT);
        check_bit("sample valve off", 1'b0, VALVE_SAMPLE_OUT);
        @(posedge REF_CLK_IN);
        REMOTE_ZERO_IN <= 1'b0;
        repeat (5) @(posedge REF_CLK_IN);
        REMOTE_SPAN_IN <= 1'b1;
        repeat (5) @(posedge REF_CLK_IN);
        REMOTE_SPAN_IN <= 1'b0;
        wait_busy(1'b0, CALC + 10);
        repeat (5) @(negedge REF_CLK_IN);
        check_bit("request not kept", 1'b0, CAL_BUSY_OUT);
        check_bit("sample valve back", 1'b1, VALVE_SAMPLE_OUT);
        @(posedge REF_CLK_IN);
        REMOTE_SPAN_IN <= 1'b1;
        wait_busy(1'b1, 10);
        check_bit("span valve", 1'b1, VALVE_SPAN_OUT);
        repeat (CALC + 20) @(negedge REF_CLK_IN);
        check_bit("repeat while held", 1'b1, CAL_BUSY_OUT);
        @(posedge REF_CLK_IN);
        REMOTE_SPAN_IN <= 1'b0;
        wait_busy(1'b0, 2 * CALC + 10);
        $display("test remote calibration done");
    endtask
    task automatic t_serial;
        logic [7:0] c0 [5];
        logic [7:0] c1 [5];
        logic [4:0] eb;
        logic [4:0] ez;
        logic [4:0] es;
        logic [4:0] ee;
        int sz;
        c0 = '{8'h61, 8'h61, 8'h73, 8'h78, 8'h73};
        c1 = '{8'h7a, 8'h73, 8'h74, 8'h71, 8'h74};
        eb = 5'h03;
        ez = 5'h01;
        es = 5'h02;
        ee = 5'h13;
        for (int i = 0; i < 5; i++) begin
            send_cmd(c0[i], c1[i]);
            repeat (3) @(negedge REF_CLK_IN);
            check_bit("command busy", eb[i], CAL_BUSY_OUT);
            check_bit("command zero valve", ez[i], VALVE_ZERO_OUT);
            check_bit("command span valve", es[i], VALVE_SPAN_OUT);
            check_bit("command status", ee[i], STATUS_EN_OUT);
            if (eb[i])
                wait_busy(1'b0, CALC + 10);
            if (i == 2) begin
                repeat (2200) @(negedge REF_CLK_IN);
                sz = i_serial_host_model.got_q.size();
                repeat (REPC + 100) @(negedge REF_CLK_IN);
                check_bit("silent while off", 1'b1,
                          i_serial_host_model.got_q.size() == sz);
            end
        end
        check_byte("frame errors", 8'h00, i_serial_host_model.frame_errs[7:0]);
        $display("test serial commands done");
    endtask
    // ========
    // Main sequence
    initial begin
        NRST_IN = 1'b0;
        REMOTE_ZERO_IN = 1'b0;
        REMOTE_SPAN_IN = 1'b0;
        CONC_IN = 16'h0123;
        RANGE_SEL_IN = 2'h0;
        ALARM_TRIP_IN = 2'h3;
        NET_IN = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (2) @(posedge REF_CLK_IN);
        NRST_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        RANGE_SEL_IN <= 2'h1;
        @(negedge REF_CLK_IN);
        t_reset_vals();
        t_report();
        t_ranges();
        t_remote_cal();
        t_serial();
        results();
    end
    // Watchdog well past the expected run of about 14000 cycles
    initial begin
        repeat (60000) @(posedge REF_CLK_IN);
        failures++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        results();
    end
endmodule // tb_top
`default_nettype wire
